/* verilog/dsc_pkg.sv */
// Purpose: Shared constants and types for the digital potentiometer shutdown command logic.
// Assumes: Command byte codes and status layout of the 256-tap volatile potentiometer.
// Notes:   One command is a command byte followed by a data byte.
package dsc_pkg;

    // Tap positions.
    localparam logic [7:0] DSC_TAP_ZERO = 8'h00;
    localparam logic [7:0] DSC_TAP_MID  = 8'h80;
    localparam logic [7:0] DSC_TAP_FULL = 8'hff;

    // Command bytes.
    localparam logic [7:0] DSC_WIPER_WRITE_CMD        = 8'h00;
    localparam logic [7:0] DSC_SHUTDOWN_RELEASE_CMD   = 8'h80;
    localparam logic [7:0] DSC_UPPER_OPEN_TAP_MID_CMD  = 8'h92;
    localparam logic [7:0] DSC_UPPER_OPEN_TAP_FULL_CMD = 8'h93;
    localparam logic [7:0] DSC_LOWER_OPEN_TAP_STORED_CMD = 8'h88;
    localparam logic [7:0] DSC_LOWER_OPEN_TAP_ZERO_CMD   = 8'h89;
    localparam logic [7:0] DSC_LOWER_OPEN_TAP_MID_CMD    = 8'h8a;
    localparam logic [7:0] DSC_LOWER_OPEN_TAP_FULL_CMD   = 8'h8b;
    localparam logic [7:0] DSC_TAP_TERMINAL_OPEN_CMD  = 8'h84;
    localparam logic [7:0] DSC_TAP_TERMINAL_OPEN_MASK = 8'hfc;
    localparam logic [7:0] DSC_PUMP_DISABLE_CMD       = 8'ha0;
    localparam logic [7:0] DSC_PUMP_ENABLE_CMD        = 8'ha1;
    localparam logic [7:0] DSC_RESET_CMD              = 8'hc0;

    // Tap override select codes.
    localparam logic [1:0] DSC_SEL_STORED = 2'h0;
    localparam logic [1:0] DSC_SEL_ZERO   = 2'h1;
    localparam logic [1:0] DSC_SEL_MID    = 2'h2;
    localparam logic [1:0] DSC_SEL_FULL   = 2'h3;

    // Configuration status bit positions.
    localparam int DSC_BIT_PUMP  = 7;
    localparam int DSC_BIT_UPPER = 4;
    localparam int DSC_BIT_LOWER = 3;
    localparam int DSC_BIT_TAP   = 2;

    localparam logic DSC_PUMP_RESET = 1'b1;

    typedef enum logic [2:0] {
        DSC_SD_NONE,
        DSC_SD_UPPER_MID,
        DSC_SD_UPPER_FULL,
        DSC_SD_LOWER_STORED,
        DSC_SD_LOWER_ZERO,
        DSC_SD_LOWER_MID,
        DSC_SD_LOWER_FULL,
        DSC_SD_TAP_OPEN
    } dsc_mode_t;

    typedef struct packed {
        logic [7:0] code;
        logic [7:0] data;
    } dsc_cmd_t;

    typedef struct packed {
        logic       pump_enabled_flag;
        logic       upper_switch_open_flag;
        logic       lower_switch_open_flag;
        logic       tap_switch_open_flag;
        logic [1:0] tap_override_select;
    } dsc_status_t;

endpackage

/* verilog/dsc_shutdown_ctrl.sv */
// Purpose: Executes wiper, shutdown, charge pump and reset commands of a 256-tap potentiometer.
// Assumes: The serial controller holds command, data and strobe steady around a link clock edge.
// Notes:   The link clock is slow, so it is sampled and its rising edge found on clk_sys.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Upper midscale shutdown forces the tap to midscale and opens the upper terminal.
// - Upper full-scale shutdown forces the tap to full scale, opens upper terminal.
// - Lower stored shutdown opens lower terminal, tap stays at the wiper register.
// - Lower zero shutdown forces the tap to zero and opens the lower terminal.
// - Lower midscale shutdown forces the tap to midscale and opens the lower terminal.
// - Lower full-scale shutdown forces the tap to full scale, opens lower terminal.
// - Tap terminal shutdown opens the tap terminal, tap stays at the wiper register.
// - Forced-position shutdowns never alter the stored wiper register.
// - Wiper writes are ignored while any shutdown is active.
// - Clearing shutdown closes terminals and returns the tap to the wiper register.
// - After lower stored shutdown clears, lower terminal closes and writes work again.
// - Reset during shutdown ends shutdown and sets the wiper to midscale.
// - Terminal shutdown commands leave the charge pump state unchanged.
// - Pump-off disables the charge pump, entering low-power mode.
// - Pump-on enables the charge pump; enabled is also the power-on state.
// - Reset loads midscale, enables the pump, clears shutdown, as after power-on.
// - Outside shutdown a wiper write stores its data and moves the tap at once.
// - Shutdown release reconnects terminals, restores the tap, keeps the pump state.
// - Status reports tap override: 00 stored, 01 zero, 10 midscale, 11 full.
// - Status reports each switch as 1 when open and pump enable as 1.
module dsc_shutdown_ctrl
    import dsc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       link_clk,
    input  wire logic       cmd_strobe,
    input  wire dsc_cmd_t   cmd_in,
    output var  logic [7:0] wiper_value,
    output var  logic [7:0] tap_position,
    output var  dsc_status_t status,
    output var  logic [7:0] config_byte,
    output var  logic       cmd_done,
    output var  logic       write_blocked
);

    logic       link_clk_meta_reg;
    logic       link_clk_sync_reg;
    logic       link_clk_prev_reg;
    logic       strobe_meta_reg;
    logic       strobe_sync_reg;
    dsc_cmd_t   cmd_meta_reg;
    dsc_cmd_t   cmd_sync_reg;

    logic       cmd_fire;
    dsc_mode_t  mode_reg;
    dsc_mode_t  mode_next;
    logic [7:0] wiper_reg;
    logic [7:0] wiper_next;
    logic       pump_reg;
    logic       pump_next;
    logic [7:0] tap_reg;
    logic [7:0] tap_next;
    dsc_status_t status_reg;
    dsc_status_t status_next;
    logic       done_reg;
    logic       blocked_reg;
    logic       is_wiper_cmd;
    logic       is_shutdown_cmd;

    // Every bit from the controller passes two flip-flops; the second is read, and for the link clock a third as well.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            link_clk_meta_reg <= 1'b0;
            link_clk_sync_reg <= 1'b0;
            link_clk_prev_reg <= 1'b0;
            strobe_meta_reg   <= 1'b0;
            strobe_sync_reg   <= 1'b0;
            cmd_meta_reg      <= '0;
            cmd_sync_reg      <= '0;
        end else begin
            link_clk_meta_reg <= link_clk;
            link_clk_sync_reg <= link_clk_meta_reg;
            link_clk_prev_reg <= link_clk_sync_reg;
            strobe_meta_reg   <= cmd_strobe;
            strobe_sync_reg   <= strobe_meta_reg;
            cmd_meta_reg      <= cmd_in;
            cmd_sync_reg      <= cmd_sync_reg == cmd_meta_reg ? cmd_sync_reg : cmd_meta_reg;
        end
    end

    // One command executes per link clock rise while the strobe is held.
    assign cmd_fire = strobe_sync_reg && link_clk_sync_reg && !link_clk_prev_reg;

    // Code decode; the data byte travels with every command and most ignore it.
    always_comb begin
        is_wiper_cmd    = cmd_sync_reg.code == DSC_WIPER_WRITE_CMD;
        is_shutdown_cmd = 1'b0;
        unique case (cmd_sync_reg.code)
            DSC_UPPER_OPEN_TAP_MID_CMD,
            DSC_UPPER_OPEN_TAP_FULL_CMD,
            DSC_LOWER_OPEN_TAP_STORED_CMD,
            DSC_LOWER_OPEN_TAP_ZERO_CMD,
            DSC_LOWER_OPEN_TAP_MID_CMD,
            DSC_LOWER_OPEN_TAP_FULL_CMD: is_shutdown_cmd = 1'b1;
            default: is_shutdown_cmd =
                (cmd_sync_reg.code & DSC_TAP_TERMINAL_OPEN_MASK) == DSC_TAP_TERMINAL_OPEN_CMD;
        endcase
    end

    // Shutdown mode: a new shutdown simply overwrites the old one.
    always_comb begin
        mode_next = mode_reg;
        if (cmd_fire) begin
            unique case (cmd_sync_reg.code)
                DSC_UPPER_OPEN_TAP_MID_CMD:    mode_next = DSC_SD_UPPER_MID;
                DSC_UPPER_OPEN_TAP_FULL_CMD:   mode_next = DSC_SD_UPPER_FULL;
                DSC_LOWER_OPEN_TAP_STORED_CMD: mode_next = DSC_SD_LOWER_STORED;
                DSC_LOWER_OPEN_TAP_ZERO_CMD:   mode_next = DSC_SD_LOWER_ZERO;
                DSC_LOWER_OPEN_TAP_MID_CMD:    mode_next = DSC_SD_LOWER_MID;
                DSC_LOWER_OPEN_TAP_FULL_CMD:   mode_next = DSC_SD_LOWER_FULL;
                DSC_SHUTDOWN_RELEASE_CMD:      mode_next = DSC_SD_NONE;
                DSC_RESET_CMD:                 mode_next = DSC_SD_NONE;
                default: begin
                    if (is_shutdown_cmd) begin
                        mode_next = DSC_SD_TAP_OPEN;
                    end
                end
            endcase
        end
    end

    // Wiper register: shutdown commands never touch it, writes are dropped in shutdown.
    always_comb begin
        wiper_next = wiper_reg;
        if (cmd_fire && cmd_sync_reg.code == DSC_RESET_CMD) begin
            wiper_next = DSC_TAP_MID;
        end else if (cmd_fire && is_wiper_cmd && mode_reg == DSC_SD_NONE) begin
            wiper_next = cmd_sync_reg.data;
        end
    end

    // Charge pump: only the pump and reset commands change it.
    always_comb begin
        pump_next = pump_reg;
        if (cmd_fire) begin
            if (cmd_sync_reg.code == DSC_PUMP_DISABLE_CMD) begin
                pump_next = 1'b0;
            end else if (cmd_sync_reg.code == DSC_PUMP_ENABLE_CMD) begin
                pump_next = 1'b1;
            end else if (cmd_sync_reg.code == DSC_RESET_CMD) begin
                pump_next = DSC_PUMP_RESET;
            end
        end
    end

    // Effective tap and switch states follow the next mode so they move with it.
    always_comb begin
        status_next = '0;
        status_next.pump_enabled_flag = pump_next;
        unique case (mode_next)
            DSC_SD_NONE: begin
                status_next.tap_override_select = DSC_SEL_STORED;
            end
            DSC_SD_UPPER_MID: begin
                status_next.upper_switch_open_flag = 1'b1;
                status_next.tap_override_select    = DSC_SEL_MID;
            end
            DSC_SD_UPPER_FULL: begin
                status_next.upper_switch_open_flag = 1'b1;
                status_next.tap_override_select    = DSC_SEL_FULL;
            end
            DSC_SD_LOWER_STORED: begin
                status_next.lower_switch_open_flag = 1'b1;
                status_next.tap_override_select    = DSC_SEL_STORED;
            end
            DSC_SD_LOWER_ZERO: begin
                status_next.lower_switch_open_flag = 1'b1;
                status_next.tap_override_select    = DSC_SEL_ZERO;
            end
            DSC_SD_LOWER_MID: begin
                status_next.lower_switch_open_flag = 1'b1;
                status_next.tap_override_select    = DSC_SEL_MID;
            end
            DSC_SD_LOWER_FULL: begin
                status_next.lower_switch_open_flag = 1'b1;
                status_next.tap_override_select    = DSC_SEL_FULL;
            end
            DSC_SD_TAP_OPEN: begin
                status_next.tap_switch_open_flag = 1'b1;
                status_next.tap_override_select  = DSC_SEL_STORED;
            end
        endcase
    end

    always_comb begin
        unique case (status_next.tap_override_select)
            DSC_SEL_ZERO: tap_next = DSC_TAP_ZERO;
            DSC_SEL_MID:  tap_next = DSC_TAP_MID;
            DSC_SEL_FULL: tap_next = DSC_TAP_FULL;
            default:      tap_next = wiper_next;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_reg <= DSC_SD_NONE;
        end else begin
            mode_reg <= mode_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wiper_reg <= DSC_TAP_MID;
        end else begin
            wiper_reg <= wiper_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pump_reg <= DSC_PUMP_RESET;
        end else begin
            pump_reg <= pump_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tap_reg    <= DSC_TAP_MID;
            status_reg <= '{pump_enabled_flag: DSC_PUMP_RESET, default: '0};
        end else begin
            tap_reg    <= tap_next;
            status_reg <= status_next;
        end
    end

    // A dropped write is reported so the controller side can see it had no effect.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            done_reg    <= 1'b0;
            blocked_reg <= 1'b0;
        end else begin
            done_reg    <= cmd_fire;
            blocked_reg <= cmd_fire && is_wiper_cmd && mode_reg != DSC_SD_NONE;
        end
    end

    assign wiper_value   = wiper_reg;
    assign tap_position  = tap_reg;
    assign status        = status_reg;
    assign cmd_done      = done_reg;
    assign write_blocked = blocked_reg;

    always_comb begin
        config_byte = '0;
        config_byte[DSC_BIT_PUMP]  = status_reg.pump_enabled_flag;
        config_byte[DSC_BIT_UPPER] = status_reg.upper_switch_open_flag;
        config_byte[DSC_BIT_LOWER] = status_reg.lower_switch_open_flag;
        config_byte[DSC_BIT_TAP]   = status_reg.tap_switch_open_flag;
        config_byte[1:0]           = status_reg.tap_override_select;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic [7:0] code_q;
    assign code_q = cmd_sync_reg.code;

    a_upper_mid_force: assert property (
        cmd_fire && code_q == DSC_UPPER_OPEN_TAP_MID_CMD
        |=> tap_position == DSC_TAP_MID && status.upper_switch_open_flag)
        else $error("Upper midscale shutdown did not force midscale.");

    a_upper_full_force: assert property (
        cmd_fire && code_q == DSC_UPPER_OPEN_TAP_FULL_CMD
        |=> tap_position == DSC_TAP_FULL && status.upper_switch_open_flag)
        else $error("Upper full-scale shutdown did not force full scale.");

    a_lower_stored_keep: assert property (
        cmd_fire && code_q == DSC_LOWER_OPEN_TAP_STORED_CMD
        |=> tap_position == wiper_value && status.lower_switch_open_flag)
        else $error("Lower stored shutdown moved the tap.");

    a_lower_zero_force: assert property (
        cmd_fire && code_q == DSC_LOWER_OPEN_TAP_ZERO_CMD
        |=> tap_position == DSC_TAP_ZERO && status.lower_switch_open_flag)
        else $error("Lower zero shutdown did not force zero.");

    a_lower_mid_force: assert property (
        cmd_fire && code_q == DSC_LOWER_OPEN_TAP_MID_CMD
        |=> tap_position == DSC_TAP_MID && status.lower_switch_open_flag)
        else $error("Lower midscale shutdown did not force midscale.");

    a_lower_full_force: assert property (
        cmd_fire && code_q == DSC_LOWER_OPEN_TAP_FULL_CMD
        |=> tap_position == DSC_TAP_FULL && status.lower_switch_open_flag)
        else $error("Lower full-scale shutdown did not force full scale.");

    a_tap_open_keep: assert property (
        cmd_fire && (code_q & DSC_TAP_TERMINAL_OPEN_MASK) == DSC_TAP_TERMINAL_OPEN_CMD
        |=> status.tap_switch_open_flag && tap_position == wiper_value)
        else $error("Tap terminal shutdown did not open the tap terminal.");

    a_shutdown_keeps_wiper: assert property (
        cmd_fire && is_shutdown_cmd |=> $stable(wiper_value))
        else $error("Shutdown command changed the wiper register.");

    a_write_blocked: assert property (
        cmd_fire && is_wiper_cmd && mode_reg != DSC_SD_NONE
        |=> $stable(wiper_value) && write_blocked)
        else $error("Wiper write took effect during shutdown.");

    a_release_restores: assert property (
        cmd_fire && code_q == DSC_SHUTDOWN_RELEASE_CMD
        |=> tap_position == wiper_value && config_byte[4:0] == 5'h00)
        else $error("Release did not restore terminals and tap.");

    // Frames are many clk_sys cycles apart, so the next write is looked for over a window.
    a_lower_reopen_write: assert property (
        mode_reg == DSC_SD_LOWER_STORED && cmd_fire && code_q == DSC_SHUTDOWN_RELEASE_CMD
        ##[1:30] cmd_fire && is_wiper_cmd && mode_reg == DSC_SD_NONE
        |=> wiper_value == $past(cmd_sync_reg.data) && !status.lower_switch_open_flag)
        else $error("Write after lower stored release was lost.");

    a_reset_defaults: assert property (
        cmd_fire && code_q == DSC_RESET_CMD
        |=> wiper_value == DSC_TAP_MID && tap_position == DSC_TAP_MID
            && mode_reg == DSC_SD_NONE && status.pump_enabled_flag)
        else $error("Reset command did not restore defaults.");

    a_shutdown_pump_kept: assert property (
        cmd_fire && (is_shutdown_cmd || code_q == DSC_SHUTDOWN_RELEASE_CMD)
        |=> status.pump_enabled_flag == $past(pump_reg))
        else $error("Shutdown command altered the charge pump.");

    a_pump_off: assert property (
        cmd_fire && code_q == DSC_PUMP_DISABLE_CMD |=> !config_byte[DSC_BIT_PUMP])
        else $error("Pump-off did not disable the charge pump.");

    a_pump_on: assert property (
        cmd_fire && code_q == DSC_PUMP_ENABLE_CMD |=> config_byte[DSC_BIT_PUMP])
        else $error("Pump-on did not enable the charge pump.");

    a_write_moves_tap: assert property (
        cmd_fire && is_wiper_cmd && mode_reg == DSC_SD_NONE
        |=> wiper_value == $past(cmd_sync_reg.data) && tap_position == wiper_value)
        else $error("Wiper write did not move the tap.");

    a_select_matches_tap: assert property (
        config_byte[1:0] != DSC_SEL_STORED
        |-> tap_position == (config_byte[1:0] == DSC_SEL_ZERO ? DSC_TAP_ZERO :
                             config_byte[1:0] == DSC_SEL_MID  ? DSC_TAP_MID  : DSC_TAP_FULL))
        else $error("Tap override select disagrees with tap.");

    a_single_open_switch: assert property (
        $onehot0(config_byte[4:2]))
        else $error("More than one terminal is open.");

    c_upper_mid: cover property (cmd_fire && code_q == DSC_UPPER_OPEN_TAP_MID_CMD);
    c_blocked_write: cover property (write_blocked);
    c_reset_in_shutdown: cover property (
        cmd_fire && code_q == DSC_RESET_CMD && mode_reg != DSC_SD_NONE);
    c_pump_cycle: cover property (!pump_reg ##[1:200] pump_reg);

endmodule

`default_nettype wire

/* verification/dsc_link_master.sv */
// Purpose: Behavioural serial controller that issues command and data bytes to the block.
// Assumes: One command is framed by one link clock pulse of 400 ns.
// Notes:   The link clock stands low between frames. The released command lines show the
//          inverse of the last word so that stale values cannot pass for held ones.
`timescale 1ns/1ps
`default_nettype none
module dsc_link_master
    import dsc_pkg::*;
(
    input  wire logic     clk_sys,
    output var  logic     link_clk,
    output var  logic     cmd_strobe,
    output var  dsc_cmd_t cmd_in
);
    initial begin
        link_clk   = 1'b0;
        cmd_strobe = 1'b0;
        cmd_in     = '0;
    end

    // Setup is the number of clk_sys cycles the word stands before the link rise.
    task automatic issue(input logic [7:0] code, input logic [7:0] data, input int setup);
        dsc_cmd_t word;
        word = {code, data};
        @(posedge clk_sys);
        cmd_in     <= word;
        cmd_strobe <= 1'b1;
        repeat (setup) @(posedge clk_sys);
        link_clk <= 1'b1;
        repeat (4) @(posedge clk_sys);
        link_clk <= 1'b0;
        repeat (4) @(posedge clk_sys);
        cmd_strobe <= 1'b0;
        cmd_in     <= ~word;
    endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Purpose: Self-checking bench for the potentiometer shutdown command logic.
// Assumes: Commands arrive through the behavioural link controller model.
// Notes:   Outputs are compared a few cycles after each frame, when they stand.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dsc_pkg::*;
    typedef struct {
        logic [7:0] code;
        logic [7:0] data;
        logic [7:0] wiper;
        logic [7:0] tap;
        logic [7:0] cfg;
        logic       blk;
    } dsc_row_t;

    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        link_clk;
    logic        cmd_strobe;
    dsc_cmd_t    cmd_in;
    logic [7:0]  wiper_value;
    logic [7:0]  tap_position;
    dsc_status_t status;
    logic [7:0]  config_byte;
    logic        cmd_done;
    logic        write_blocked;
    int          fail_count = 0;
    int          n_tests    = 0;
    int          done_cnt   = 0;
    int          blk_cnt    = 0;
    int          d0;
    int          b0;

    // Each row is one command and the state expected after it.
    dsc_row_t rows [21] = '{
        '{8'h00, 8'h37, 8'h37, 8'h37, 8'h80, 1'b0},
        '{8'h92, 8'h00, 8'h37, 8'h80, 8'h92, 1'b0},
        '{8'h00, 8'h55, 8'h37, 8'h80, 8'h92, 1'b1},
        '{8'h93, 8'h00, 8'h37, 8'hff, 8'h93, 1'b0},
        '{8'h89, 8'hff, 8'h37, 8'h00, 8'h89, 1'b0},
        '{8'h8a, 8'h00, 8'h37, 8'h80, 8'h8a, 1'b0},
        '{8'h8b, 8'h00, 8'h37, 8'hff, 8'h8b, 1'b0},
        '{8'h88, 8'h00, 8'h37, 8'h37, 8'h88, 1'b0},
        '{8'h80, 8'h00, 8'h37, 8'h37, 8'h80, 1'b0},
        '{8'h00, 8'h5a, 8'h5a, 8'h5a, 8'h80, 1'b0},
        '{8'h84, 8'h12, 8'h5a, 8'h5a, 8'h84, 1'b0},
        '{8'h87, 8'h00, 8'h5a, 8'h5a, 8'h84, 1'b0},
        '{8'ha0, 8'h00, 8'h5a, 8'h5a, 8'h04, 1'b0},
        '{8'h8b, 8'h00, 8'h5a, 8'hff, 8'h0b, 1'b0},
        '{8'hc0, 8'h00, 8'h80, 8'h80, 8'h80, 1'b0},
        '{8'ha0, 8'h00, 8'h80, 8'h80, 8'h00, 1'b0},
        '{8'h80, 8'h00, 8'h80, 8'h80, 8'h00, 1'b0},
        '{8'ha1, 8'h00, 8'h80, 8'h80, 8'h80, 1'b0},
        '{8'h00, 8'hff, 8'hff, 8'hff, 8'h80, 1'b0},
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 1'b0},
        '{8'h90, 8'h00, 8'h00, 8'h00, 8'h80, 1'b0}
    };

    always #50 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        if (cmd_done === 1'b1) begin
            done_cnt++;
        end
        if (write_blocked === 1'b1) begin
            blk_cnt++;
        end
    end

    dsc_link_master dsc_link_master_inst (
        .clk_sys    (clk_sys),
        .link_clk   (link_clk),
        .cmd_strobe (cmd_strobe),
        .cmd_in     (cmd_in)
    );

    dsc_shutdown_ctrl dsc_shutdown_ctrl_inst (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .link_clk      (link_clk),
        .cmd_strobe    (cmd_strobe),
        .cmd_in        (cmd_in),
        .wiper_value   (wiper_value),
        .tap_position  (tap_position),
        .status        (status),
        .config_byte   (config_byte),
        .cmd_done      (cmd_done),
        .write_blocked (write_blocked)
    );

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic check_state(input logic [7:0] w, input logic [7:0] t, input logic [7:0] c);
        check("wiper_value", {8'h00, wiper_value}, {8'h00, w});
        check("tap_position", {8'h00, tap_position}, {8'h00, t});
        check("config_byte", {8'h00, config_byte}, {8'h00, c});
        check("status", {10'h000, status}, {10'h000, c[7], c[4:0]});
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge clk_sys);
        fail_count++;
        final_report();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check_state(8'h80, 8'h80, 8'h80);
        $display("test power_on done");
        foreach (rows[i]) begin
            d0 = done_cnt;
            b0 = blk_cnt;
            dsc_link_master_inst.issue(rows[i].code, rows[i].data, 3);
            repeat (2) @(posedge clk_sys);
            check_state(rows[i].wiper, rows[i].tap, rows[i].cfg);
            check("cmd_done", 16'(done_cnt - d0), 16'h0001);
            check("write_blocked", 16'(blk_cnt - b0), {15'h0000, rows[i].blk});
            $display("test row %0d done", i);
        end
        // A slow controller sends back to back; the write after the shutdown is refused.
        b0 = blk_cnt;
        dsc_link_master_inst.issue(8'h00, 8'h11, 6);
        dsc_link_master_inst.issue(8'h89, 8'h00, 6);
        dsc_link_master_inst.issue(8'h00, 8'h22, 3);
        repeat (2) @(posedge clk_sys);
        check_state(8'h11, 8'h00, 8'h89);
        check("write_blocked", 16'(blk_cnt - b0), 16'h0001);
        $display("test slow_back_to_back done");
        // A reset in mid-shutdown must bring back the power-on state.
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check_state(8'h80, 8'h80, 8'h80);
        dsc_link_master_inst.issue(8'h00, 8'h44, 3);
        repeat (2) @(posedge clk_sys);
        check_state(8'h44, 8'h44, 8'h80);
        $display("test midrun_reset done");
        final_report();
    end
endmodule
`default_nettype wire
